/* File: logic/ftm_fan_monitor.sv */
`default_nettype none

module ftm_fan_monitor #(
  parameter int unsigned TB_CYCLES = ftm_pkg::TIMEBASE_CYCLES,
  parameter int unsigned FILT_CYCLES = ftm_pkg::FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire ftm_pkg::ftm_bus_req_type bus_req,
  output logic [7:0] reg_rdata,
  input wire logic tach_level,
  output logic tach_drive,
  output logic tach_drive_en,
  input wire logic gpio_drive,
  input wire logic gpio_drive_en,
  input wire logic bypass_drive,
  output logic irq_n
);

  localparam int unsigned TB_W = (TB_CYCLES > 1) ? $clog2(TB_CYCLES) : 1;
  localparam int unsigned FL_W = (FILT_CYCLES > 1) ? $clog2(FILT_CYCLES + 1) : 1;
  localparam logic [TB_W-1:0] TB_LAST = TB_W'(TB_CYCLES - 1);
  localparam logic [FL_W-1:0] FL_LAST = FL_W'(FILT_CYCLES);

  // register state
  ftm_pkg::ftm_ctrl_type ctrl_q;
  logic [7:0] limit_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] bypass_q;
  logic [7:0] source_q;
  logic [7:0] source_d;
  logic [7:0] rdata_q;
  logic irq_n_q;
  logic drive_q;
  logic drive_en_q;

  // measurement state
  ftm_pkg::ftm_state_type state_q;
  ftm_pkg::ftm_state_type state_d;
  logic [TB_W-1:0] tb_cnt_q;
  logic [3:0] pre_cnt_q;
  logic [7:0] meas_q;
  logic [7:0] meas_d;
  logic half_q;
  logic filt_q;
  logic filt_prev_q;
  logic [FL_W-1:0] flt_cnt_q;

  // bus decode
  wire wr_ctrl = bus_req.we && (bus_req.addr == ftm_pkg::ADDR_CTRL);
  wire wr_limit = bus_req.we && (bus_req.addr == ftm_pkg::ADDR_LIMIT);
  wire wr_stat = bus_req.we && (bus_req.addr == ftm_pkg::ADDR_STATUS);
  wire wr_mask = bus_req.we && (bus_req.addr == ftm_pkg::ADDR_MASK);
  wire wr_bypass = bus_req.we && (bus_req.addr == ftm_pkg::ADDR_BYPASS);
  wire [1:0] stat_clr = wr_stat ? bus_req.wdata[1:0] : 2'h0;

  // write data seen as control fields; reserved bits are dropped
  ftm_pkg::ftm_ctrl_type wr_ctrl_val;
  assign wr_ctrl_val = bus_req.wdata;

  // enable gates interrupt enable and time base (not bypass) so stale interrupt and divisor settings stay inert
  wire mon_en = ctrl_q.en;
  wire irq_en = ctrl_q.en && ctrl_q.ien;
  wire [3:0] div_val = ftm_pkg::ftm_divisor(ctrl_q.div);
  wire bypass_on = |bypass_q;

  // time base: one enable pulse every TB_CYCLES clocks gives 20 kHz
  wire tb_tick = mon_en && (tb_cnt_q == TB_LAST);

  // prescaler applies the divisor ahead of the counter
  wire pre_last = (pre_cnt_q == (div_val - 4'h1));
  wire cnt_tick = tb_tick && pre_last;

  // filtered tach edges; two rising edges make one revolution
  wire tach_rise = filt_q && !filt_prev_q;
  wire measuring = (state_q == ftm_pkg::FTM_MEASURE);
  wire rev_end = measuring && tach_rise && half_q;
  wire meas_sat = (meas_q == ftm_pkg::COUNT_MAX);

  // overflow: live counter at or above the limit, only with interrupts enabled
  wire frozen = irq_en && stat_q[ftm_pkg::STAT_OVF_BIT];
  wire ovf_event = irq_en && measuring && (meas_q >= limit_q) && !stat_q[ftm_pkg::STAT_OVF_BIT];
  wire upd_event = rev_end && !frozen;
  wire ovf_cleared = stat_clr[ftm_pkg::STAT_OVF_BIT] && stat_q[ftm_pkg::STAT_OVF_BIT] && !ovf_event;
  wire restart = irq_en && ovf_cleared;

  // sticky status: a new event wins over a clear in the same cycle
  assign stat_d = (stat_q & ~stat_clr) | {upd_event, ovf_event};

  // interrupt source follows the overflow flag
  assign source_d = ovf_event ? ftm_pkg::SOURCE_CODE :
                    ovf_cleared ? ftm_pkg::SOURCE_NONE : source_q;

  // next measurement count: restart per revolution, saturate when the fan stalls
  always_comb begin
    meas_d = meas_q;
    if (!measuring || rev_end || restart) begin
      meas_d = ftm_pkg::COUNT_ZERO;
    end else if (cnt_tick && !meas_sat) begin
      meas_d = meas_q + 8'h01;
    end
  end

  // published count: held while frozen, refreshed each revolution otherwise
  always_comb begin
    count_d = count_q;
    if (!mon_en || restart) begin
      count_d = ftm_pkg::COUNT_ZERO;
    end else if (frozen) begin
      count_d = count_q;
    end else if (rev_end) begin
      count_d = meas_q;
    end else if (measuring && meas_sat) begin
      count_d = ftm_pkg::COUNT_MAX;
    end
  end

  // sequencing: the first edge only arms, so a partial revolution is never published
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ftm_pkg::FTM_IDLE: begin
        if (mon_en) begin
          state_d = ftm_pkg::FTM_ARM;
        end
      end
      ftm_pkg::FTM_ARM: begin
        if (tach_rise) begin
          state_d = ftm_pkg::FTM_MEASURE;
        end
      end
      ftm_pkg::FTM_MEASURE: begin
        if (restart) begin
          state_d = ftm_pkg::FTM_ARM;
        end
      end
    endcase
    if (!mon_en) begin
      state_d = ftm_pkg::FTM_IDLE;
    end
  end

  // read mux; unmapped addresses read zero
  wire [7:0] ctrl_rd = {ctrl_q.en, ctrl_q.ien, 4'h0, ctrl_q.div};
  wire [7:0] bypass_rd = {1'b0, bypass_q, 5'h00};
  wire [7:0] rd_mux = (bus_req.addr == ftm_pkg::ADDR_CTRL) ? ctrl_rd :
                      (bus_req.addr == ftm_pkg::ADDR_LIMIT) ? limit_q :
                      (bus_req.addr == ftm_pkg::ADDR_COUNT) ? count_q :
                      (bus_req.addr == ftm_pkg::ADDR_STATUS) ? {6'h00, stat_q} :
                      (bus_req.addr == ftm_pkg::ADDR_MASK) ? {6'h00, mask_q} :
                      (bus_req.addr == ftm_pkg::ADDR_BYPASS) ? bypass_rd :
                      (bus_req.addr == ftm_pkg::ADDR_SOURCE) ? source_q : 8'h00;

  // pin: bypass outranks monitoring, monitoring outranks the general purpose setup
  wire pin_drive_en_d = bypass_on ? 1'b1 :
                        mon_en ? 1'b0 : gpio_drive_en;
  wire pin_drive_d = bypass_on ? bypass_drive : (mon_en ? 1'b0 : gpio_drive);

  // software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= ftm_pkg::CTRL_RESET;
      limit_q <= ftm_pkg::LIMIT_RESET;
      mask_q <= ftm_pkg::MASK_RESET;
      bypass_q <= ftm_pkg::BYPASS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= {wr_ctrl_val.en, wr_ctrl_val.ien, 4'h0, wr_ctrl_val.div};
      end
      if (wr_limit) begin
        limit_q <= bus_req.wdata;
      end
      if (wr_mask) begin
        mask_q <= bus_req.wdata[1:0];
      end
      if (wr_bypass) begin
        bypass_q <= bus_req.wdata[ftm_pkg::BYPASS_HI_BIT:ftm_pkg::BYPASS_LO_BIT];
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= bus_req.re ? rd_mux : 8'h00;
    end
  end

  // tach filter: a level must hold FILT_CYCLES + 1 clocks before it is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
      flt_cnt_q <= '0;
    end else begin
      filt_prev_q <= filt_q;
      if (!mon_en || tach_level == filt_q) begin
        flt_cnt_q <= '0;
      end else if (flt_cnt_q == FL_LAST) begin
        filt_q <= tach_level;
        flt_cnt_q <= '0;
      end else begin
        flt_cnt_q <= flt_cnt_q + FL_W'(1);
      end
    end
  end

  // time base and prescaler; both realign at each revolution edge
  always_ff @(posedge clk) begin
    if (rst) begin
      tb_cnt_q <= '0;
      pre_cnt_q <= 4'h0;
    end else if (!mon_en || rev_end || restart) begin
      tb_cnt_q <= '0;
      pre_cnt_q <= 4'h0;
    end else begin
      tb_cnt_q <= tb_tick ? '0 : tb_cnt_q + TB_W'(1);
      if (tb_tick) begin
        pre_cnt_q <= pre_last ? 4'h0 : pre_cnt_q + 4'h1;
      end
    end
  end

  // pulse pairing and measurement counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ftm_pkg::FTM_IDLE;
      half_q <= 1'b0;
      meas_q <= ftm_pkg::COUNT_ZERO;
    end else begin
      state_q <= state_d;
      meas_q <= meas_d;
      if (state_d != ftm_pkg::FTM_MEASURE) begin
        half_q <= 1'b0;
      end else if (measuring && tach_rise) begin
        half_q <= !half_q;
      end
    end
  end

  // published count, status, source
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= ftm_pkg::COUNT_ZERO;
      stat_q <= ftm_pkg::STAT_RESET;
      source_q <= ftm_pkg::SOURCE_NONE;
    end else begin
      count_q <= count_d;
      stat_q <= stat_d;
      source_q <= source_d;
    end
  end

  // outputs: interrupt lags status by one clock so it comes from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n_q <= 1'b1;
      drive_q <= 1'b0;
      drive_en_q <= 1'b0;
    end else begin
      irq_n_q <= !(|(stat_q & mask_q));
      drive_q <= pin_drive_d;
      drive_en_q <= pin_drive_en_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_n = irq_n_q;
  assign tach_drive = drive_q;
  assign tach_drive_en = drive_en_q;

endmodule // ftm_fan_monitor

`default_nettype wire

/* File: logic/ftm_pkg.sv */
`default_nettype none

package ftm_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TIMEBASE_HZ = 20_000;
  localparam int unsigned TIMEBASE_CYCLES = CLK_HZ / TIMEBASE_HZ;
  // least stable time before a tach level is believed; rounds up
  localparam int unsigned FILTER_TIME_NS = 2000;
  localparam int unsigned FILTER_CYCLES = (FILTER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PULSES_PER_REV = 2;

  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h38;
  localparam logic [7:0] ADDR_LIMIT = 8'h39;
  localparam logic [7:0] ADDR_COUNT = 8'h3A;
  localparam logic [7:0] ADDR_STATUS = 8'h3C;
  localparam logic [7:0] ADDR_MASK = 8'h3D;
  localparam logic [7:0] ADDR_BYPASS = 8'h3E;
  localparam logic [7:0] ADDR_SOURCE = 8'h3F;

  // reset values and codes
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] SOURCE_NONE = 8'h00;
  localparam logic [7:0] SOURCE_CODE = ADDR_CTRL;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [1:0] BYPASS_RESET = 2'h0;

  // field positions
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned STAT_UPD_BIT = 1;
  localparam int unsigned BYPASS_LO_BIT = 5;
  localparam int unsigned BYPASS_HI_BIT = 6;

  typedef struct packed {
    logic en;
    logic ien;
    logic [3:0] rsv;
    logic [1:0] div;
  } ftm_ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ftm_bus_req_type;

  typedef enum logic [1:0] {
    FTM_IDLE,
    FTM_ARM,
    FTM_MEASURE
  } ftm_state_type;

  // divisor decode
  function automatic logic [3:0] ftm_divisor(input logic [1:0] sel);
    logic [3:0] d;
    d = 4'h1;
    unique case (sel)
      2'h0: d = 4'h1;
      2'h1: d = 4'h2;
      2'h2: d = 4'h4;
      2'h3: d = 4'h8;
    endcase
    return d;
  endfunction

endpackage

`default_nettype wire

/* File: tb/ftm_fan_monitor_properties.sv */
`default_nettype none

module ftm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire ftm_pkg::ftm_bus_req_type bus_req,
  input wire logic [7:0] reg_rdata,
  input wire logic tach_drive,
  input wire logic tach_drive_en,
  input wire logic gpio_drive,
  input wire logic gpio_drive_en,
  input wire logic bypass_drive,
  input wire logic irq_n
);
  // write and read decodes seen on the register port
  wire logic wr_ctrl = bus_req.we && bus_req.addr == 8'h38;
  wire logic wr_byp = bus_req.we && bus_req.addr == 8'h3E;
  wire logic wr_msk = bus_req.we && bus_req.addr == 8'h3D;
  wire logic wr_stat = bus_req.we && bus_req.addr == 8'h3C;
  wire logic rd_cnt = bus_req.re && bus_req.addr == 8'h3A;
  wire logic rd_src = bus_req.re && bus_req.addr == 8'h3F;
  logic en_q, ien_q, byp_q, msk1_q;

  // shadow of the config bits, updated on the same edge as the block's own registers
  always_ff @(posedge clk) begin
    if (rst) begin
      {en_q, ien_q, byp_q, msk1_q} <= 4'h0;
    end else begin
      if (wr_ctrl) {en_q, ien_q} <= bus_req.wdata[7:6];
      if (wr_byp) byp_q <= |bus_req.wdata[6:5];
      if (wr_msk) msk1_q <= bus_req.wdata[1];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // pin and irq outputs are registered, so three settled cycles are allowed
  AST_RESET_QUIET: assert property (@(posedge clk) disable iff (1'b0) rst |=> irq_n && !tach_drive_en)
    else $error("outputs not quiet after reset");
  AST_RDATA_IDLE: assert property (!bus_req.re |=> reg_rdata == 8'h00)
    else $error("read data outside a read cycle");
  AST_PIN_INPUT: assert property ((en_q && !byp_q)[*3] |-> !tach_drive_en)
    else $error("monitor pin still driven");
  AST_PIN_BYPASS: assert property (byp_q[*3] |-> tach_drive_en && tach_drive == $past(bypass_drive))
    else $error("bypass does not drive the pin");
  AST_PIN_GPIO: assert property ((!en_q && !byp_q)[*3] |->
    tach_drive_en == $past(gpio_drive_en) && tach_drive == $past(gpio_drive))
    else $error("pin not left to gpio while disabled");
  AST_IRQ_OFF: assert property (!ien_q && !msk1_q && irq_n |=> irq_n)
    else $error("irq raised with irq enable clear");
  AST_IRQ_CLEAR: assert property (wr_stat && bus_req.wdata[0] && !msk1_q |-> ##[1:3] irq_n)
    else $error("irq stays after clear");
  AST_COUNT_OFF: assert property ((!en_q)[*2] ##0 rd_cnt |=> reg_rdata == 8'h00)
    else $error("count nonzero while disabled");
  AST_SRC_CODE: assert property (rd_src |=> reg_rdata == 8'h00 || reg_rdata == 8'h38)
    else $error("bad interrupt source code");

  COV_IRQ: cover property ($fell(irq_n));
  COV_BYPASS: cover property (byp_q && tach_drive_en);
  COV_SATURATE: cover property (rd_cnt ##1 reg_rdata == 8'hFF);
endmodule // ftm_chk

`default_nettype wire

/* File: tb/ftm_fan_model.sv */
`default_nettype none

module ftm_fan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] half_rev,
  input wire logic glitch,
  output logic tach
);
  logic [15:0] cnt_q;

  // one tach period per half revolution, so two pulses per turn
  always_ff @(posedge clk) begin
    if (rst || cnt_q >= half_rev - 16'h0001) cnt_q <= 16'h0000;
    else cnt_q <= cnt_q + 16'h0001;
  end

  // low then high half; a two-cycle spike in the low half mimics a ringing slow edge
  assign tach = (cnt_q >= (half_rev >> 1)) || (glitch && cnt_q[15:1] == 15'h0005);
endmodule // ftm_fan_model

`default_nettype wire

/* File: tb/ftm_fan_monitor_tb_top.sv */
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module ftm_fan_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAP [8] = '{8'h38, 8'h39, 8'h3A, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40};
  logic clk = 1'b0;
  logic rst = 1'b1;
  ftm_pkg::ftm_bus_req_type bus_req = '0;
  logic glitch = 1'b0;
  logic [15:0] half_rev = 16'h012C;
  logic [7:0] reg_rdata, rd_q, held;
  logic tach_drive, tach_drive_en, irq_n, fan;
  wire logic tach_level;
  int n_mismatch = 0;
  int checks = 0;

  // shared pin: the block wins while it enables its driver
  assign tach_level = tach_drive_en ? tach_drive : fan;
  always #12.5 clk = ~clk;

  // small time base and filter keep the run short
  ftm_fan_monitor #(.TB_CYCLES(4), .FILT_CYCLES(2)) uut (.clk(clk), .rst(rst), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .tach_level(tach_level), .tach_drive(tach_drive), .tach_drive_en(tach_drive_en),
    .gpio_drive(1'b0), .gpio_drive_en(1'b1), .bypass_drive(1'b1), .irq_n(irq_n));
  ftm_fan_model fan_m (.clk(clk), .rst(rst), .half_rev(half_rev), .glitch(glitch), .tach(fan));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk) bus_req <= '0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk) bus_req <= '0;
    #1 rd_q = reg_rdata;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_upd();
    rd_q = 8'h00;
    for (int i = 0; i < 5000 && rd_q[1] !== 1'b1; i++) rd(8'h3C);
    `CHK(rd_q[1], 1'b1)
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // all registers clear, unmapped 40h reads zero
    foreach (MAP[i]) begin
      rd(MAP[i]);
      `CHK(rd_q, 8'h00)
    end
    wr(8'h39, 8'hA5);
    wr(8'h3A, 8'h55);
    rd(8'h39);
    `CHK(rd_q, 8'hA5)
    rd(8'h3A);
    `CHK(rd_q, 8'h00)
    $display("test registers done");
    // irq enable and divisor alone leave the pin to gpio
    wr(8'h38, 8'h43);
    settle();
    `CHK({tach_drive_en, tach_drive, irq_n}, 3'b101)
    wr(8'h38, 8'h80);
    settle();
    `CHK(tach_drive_en, 1'b0)
    wr(8'h3E, 8'h60);
    settle();
    `CHK({tach_drive_en, tach_drive}, 2'b11)
    wr(8'h3E, 8'h00);
    $display("test pin done");
    // each divisor with the fan speed that gives 150, spikes on the line
    wr(8'h39, 8'h00);
    wr(8'h3D, 8'h01);
    @(posedge clk) glitch <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) half_rev <= 16'h012C << s;
      wr(8'h38, 8'h00);
      wr(8'h3C, 8'h03);
      wr(8'h38, 8'h80 | 8'(s));
      rd(8'h3A);
      `CHK(rd_q, 8'h00)
      wait_upd();
      wr(8'h3C, 8'h02);
      wait_upd();
      rd(8'h3A);
      `CHK(rd_q inside {[8'h95:8'h97]}, 1'b1)
      rd(8'h3C);
      `CHK({rd_q[0], irq_n}, 2'b01)
    end
    $display("test divisors done");
    // overflow raises the irq and holds the count until cleared
    @(posedge clk) half_rev <= 16'h012C;
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h03);
    wr(8'h39, 8'h64);
    // publish one polled count first, so the frozen value is a real measurement and not the cleared zero
    wr(8'h38, 8'h80);
    wait_upd();
    wr(8'h38, 8'hC0);
    for (int i = 0; i < 3000 && irq_n !== 1'b0; i++) @(posedge clk);
    `CHK(irq_n, 1'b0)
    rd(8'h3F);
    `CHK(rd_q, 8'h38)
    rd(8'h3A);
    held = rd_q;
    `CHK(held inside {[8'h95:8'h97]}, 1'b1)
    repeat (700) @(posedge clk);
    rd(8'h3A);
    `CHK(rd_q, held)
    wr(8'h3C, 8'h01);
    rd(8'h3F);
    `CHK({rd_q, irq_n}, 9'h001)
    rd(8'h3A);
    `CHK(rd_q, 8'h00)
    $display("test interrupt done");
    // a very slow fan runs the count into saturation
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h03);
    @(posedge clk) half_rev <= 16'h2710;
    wr(8'h38, 8'h80);
    repeat (7000) @(posedge clk);
    rd(8'h3A);
    `CHK(rd_q, 8'hFF)
    $display("test saturation done");
    print_verdict();
  end

  // the tests need about 30k cycles; this cuts a hang at 100k
  initial begin
    #2500000;
    n_mismatch++;
    print_verdict();
  end
endmodule // ftm_fan_monitor_tb_top

bind ftm_fan_monitor ftm_chk chk (.clk(clk), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
  .tach_drive(tach_drive), .tach_drive_en(tach_drive_en), .gpio_drive(gpio_drive), .gpio_drive_en(gpio_drive_en),
  .bypass_drive(bypass_drive), .irq_n(irq_n));

`default_nettype wire
